// *** rtl/rsc_pkg.sv ***
// Package of the reset source combiner: register map, bit layout,
// values after reset and bus widths.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package rsc_pkg;

  // Bus widths
  localparam int RSC_ADR_W = 8;
  localparam int RSC_DAT_W = 32;
  localparam int RSC_SEL_W = 4;

  // Register byte offsets
  localparam logic [7:0] RSC_OFF_CAUSE = 8'h00;
  localparam logic [7:0] RSC_OFF_LIVE = 8'h04;

  // Bit positions in reset_cause_status
  localparam int RSC_B_POWER_ON = 0;
  localparam int RSC_B_SUPPLY_DIP = 1;
  localparam int RSC_B_IDLE = 2;
  localparam int RSC_B_SLEEP = 3;
  localparam int RSC_B_WATCHDOG_TIMEOUT = 4;
  localparam int RSC_B_SOFT_WATCHDOG = 5;
  localparam int RSC_B_RESET_INSTR = 6;
  localparam int RSC_B_EXTERNAL_PIN = 7;
  localparam int RSC_B_REG_STANDBY = 8;
  localparam int RSC_B_CONFIG_MISMATCH = 9;
  localparam int RSC_B_ILLEGAL_COND = 14;
  localparam int RSC_B_TRAP_CONFLICT = 15;

  // Implemented bits; 13..10 read as zero
  localparam logic [15:0] RSC_CAUSE_IMPL = 16'hc3ff;
  // Value loaded while rst_n is low
  localparam logic [15:0] RSC_CAUSE_RESET = 16'h0003;
  // Value left behind by a power-on event
  localparam logic [15:0] RSC_CAUSE_POWER_ON = 16'h0001;

  // Number of live source lines shown in the live register
  localparam int RSC_NUM_SRC = 10;

endpackage

// *** rtl/rsc_wb_slave.sv ***
// Classic Wishbone slave front end of the reset source combiner.
// Assumes a single-cycle master that holds the request until ack.
`timescale 1ns/1ns
module rsc_wb_slave (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rsc_pkg::RSC_ADR_W-1:0] wb_adr_i,
  output logic wb_ack_o,
  output logic [rsc_pkg::RSC_DAT_W-1:0] wb_dat_o,
  // Register side
  input wire logic [15:0] cause_word,
  input wire logic [rsc_pkg::RSC_NUM_SRC-1:0] live_word,
  output logic wr_cause
);

  logic req;

  // Request present and not yet answered
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Write lands on the edge that samples ack high
  assign wr_cause = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_adr_i == rsc_pkg::RSC_OFF_CAUSE);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data captured with ack; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      if (wb_adr_i == rsc_pkg::RSC_OFF_CAUSE) begin
        wb_dat_o <= {16'h0000, cause_word};
      end else if (wb_adr_i == rsc_pkg::RSC_OFF_LIVE) begin
        wb_dat_o <= {22'h0, live_word};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule

// *** rtl/rsc_reset_combiner.sv ***
// Reset source combiner: merges all reset sources into the master
// system reset and keeps the reset cause flags for software.
// Assumes source lines are synchronous levels to core_clk and that
// software reaches the registers over classic Wishbone.
//
// Overview of operation
// - Any active source drives the master reset.
// - Eight source kinds feed the combiner.
// - Opcode, uninitialised register or security raise illegal.
// - System reset forces some state, keeps flags.
// - Each reset sets its own cause flag.
// - Power-on clears all flags except those of events in the same cycle.
// - Software may set or clear any flag.
// - Software setting a flag never causes reset.
// - Bits 13 to 10 read as zero.
// - Register also holds watchdog, sleep, idle, standby.
// - Supply dip flag marks a brown-out reset.
// - Power-on flag marks a power-on reset.
// - Unprogrammed fuse keeps watchdog always enabled.
// - Power-on and brown-out are cold, others warm.
`timescale 1ns/1ns
module rsc_reset_combiner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Reset sources
  input wire logic src_power_on,
  input wire logic src_supply_dip,
  input wire logic external_pin_reset,
  input wire logic src_reset_instr,
  input wire logic src_watchdog,
  input wire logic src_config_mismatch,
  input wire logic src_trap_conflict,
  input wire logic src_illegal_opcode,
  input wire logic src_uninit_wreg,
  input wire logic src_security,
  // Power-saving and configuration inputs
  input wire logic sleep_entered,
  input wire logic idle_entered,
  input wire logic fused_watchdog_enable,
  // Reset and control outputs
  output logic master_system_reset,
  output logic cold_reset,
  output logic warm_reset,
  output logic watchdog_enable,
  output logic regulator_standby_bit,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rsc_pkg::RSC_ADR_W-1:0] wb_adr_i,
  input wire logic [rsc_pkg::RSC_SEL_W-1:0] wb_sel_i,
  input wire logic [rsc_pkg::RSC_DAT_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [rsc_pkg::RSC_DAT_W-1:0] wb_dat_o
);

  logic [15:0] reset_cause_status;
  logic [15:0] next_cause;
  logic [15:0] hw_set;
  logic [15:0] lane_mask;
  logic [15:0] wr_word;
  logic [rsc_pkg::RSC_NUM_SRC-1:0] live_src;
  logic illegal_src;
  logic cold_src;
  logic warm_src;
  logic any_src;
  logic wr_cause;

  // Illegal-condition source from its three causes
  assign illegal_src = src_illegal_opcode | src_uninit_wreg | src_security;

  // Cold and warm groups of the sources
  assign cold_src = src_power_on | src_supply_dip;
  assign warm_src = external_pin_reset | src_reset_instr | src_watchdog
                  | src_config_mismatch | src_trap_conflict | illegal_src;

  // Any active source asks for the master reset
  assign any_src = cold_src | warm_src;

  // Live view of all source lines for the second register
  assign live_src = {src_security, src_uninit_wreg, src_illegal_opcode, src_trap_conflict,
                     src_config_mismatch, src_watchdog, src_reset_instr, external_pin_reset,
                     src_supply_dip, src_power_on};

  // Register bus front end
  rsc_wb_slave u_wb_slave (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .cause_word(reset_cause_status),
    .live_word(live_src),
    .wr_cause(wr_cause)
  );

  // Byte lanes that a write touches, limited to implemented bits
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & rsc_pkg::RSC_CAUSE_IMPL;
  assign wr_word = wb_dat_i[15:0];

  // Flags raised by hardware events this cycle
  always_comb begin
    hw_set = 16'h0000;
    hw_set[rsc_pkg::RSC_B_POWER_ON] = src_power_on;
    hw_set[rsc_pkg::RSC_B_SUPPLY_DIP] = src_supply_dip;
    hw_set[rsc_pkg::RSC_B_EXTERNAL_PIN] = external_pin_reset;
    hw_set[rsc_pkg::RSC_B_RESET_INSTR] = src_reset_instr;
    hw_set[rsc_pkg::RSC_B_WATCHDOG_TIMEOUT] = src_watchdog;
    hw_set[rsc_pkg::RSC_B_CONFIG_MISMATCH] = src_config_mismatch;
    hw_set[rsc_pkg::RSC_B_TRAP_CONFLICT] = src_trap_conflict;
    hw_set[rsc_pkg::RSC_B_ILLEGAL_COND] = illegal_src;
    hw_set[rsc_pkg::RSC_B_SLEEP] = sleep_entered;
    hw_set[rsc_pkg::RSC_B_IDLE] = idle_entered;
  end

  // Next flag value per bit: write, then power-on clear, then set wins
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cause_bit
      always_comb begin
        if (!rsc_pkg::RSC_CAUSE_IMPL[gi]) begin
          next_cause[gi] = 1'b0;
        end else if (src_power_on) begin
          next_cause[gi] = hw_set[gi];
        end else if (any_src && gi == rsc_pkg::RSC_B_SOFT_WATCHDOG) begin
          next_cause[gi] = 1'b0;
        end else if (hw_set[gi]) begin
          next_cause[gi] = 1'b1;
        end else if (wr_cause && lane_mask[gi]) begin
          next_cause[gi] = wr_word[gi];
        end else begin
          next_cause[gi] = reset_cause_status[gi];
        end
      end
    end
  endgenerate

  // Cause register; a write only stores bits and starts no reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reset_cause_status <= rsc_pkg::RSC_CAUSE_RESET;
    end else begin
      reset_cause_status <= next_cause;
    end
  end

  // Master reset and its cold or warm kind
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      master_system_reset <= 1'b1;
      cold_reset <= 1'b1;
      warm_reset <= 1'b0;
    end else begin
      master_system_reset <= any_src;
      cold_reset <= cold_src;
      warm_reset <= warm_src & ~cold_src;
    end
  end

  // Watchdog stays on while the fuse is unprogrammed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      watchdog_enable <= 1'b1;
    end else begin
      watchdog_enable <= fused_watchdog_enable | next_cause[rsc_pkg::RSC_B_SOFT_WATCHDOG];
    end
  end

  // Regulator standby control taken from the register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regulator_standby_bit <= 1'b0;
    end else begin
      regulator_standby_bit <= next_cause[rsc_pkg::RSC_B_REG_STANDBY];
    end
  end

  // Checks of the combiner behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Master reset follows the sources one cycle later
  AST_MASTER_RESET_FOLLOWS: assert property (
    rst_n |=> (master_system_reset == $past(any_src)))
    else $error("master reset does not follow the sources");

  // A lone watchdog time-out sets its flag
  AST_WATCHDOG_FLAG: assert property (
    src_watchdog && !src_power_on |=> reset_cause_status[rsc_pkg::RSC_B_WATCHDOG_TIMEOUT])
    else $error("watchdog time-out flag not set");

  // Power-on alone leaves only the power-on flag
  AST_POWER_ON_CLEARS: assert property (
    src_power_on && !src_supply_dip && !warm_src && !sleep_entered && !idle_entered
    |=> reset_cause_status == rsc_pkg::RSC_CAUSE_POWER_ON)
    else $error("power-on did not leave only its own flag");

  // Unimplemented bits stay zero
  AST_UNIMPL_ZERO: assert property (
    reset_cause_status[13:10] == 4'h0)
    else $error("unimplemented bits are not zero");

  // Security event marks the illegal-condition flag and resets
  AST_SECURITY_ILLEGAL: assert property (
    src_security && !src_power_on
    |=> reset_cause_status[rsc_pkg::RSC_B_ILLEGAL_COND] && master_system_reset)
    else $error("security event not recorded as illegal condition");

  // Pointer fault marks the illegal-condition flag
  AST_UNINIT_ILLEGAL: assert property (
    src_uninit_wreg && !src_power_on |=> reset_cause_status[rsc_pkg::RSC_B_ILLEGAL_COND])
    else $error("uninitialised register fault not recorded");

  // Two sources at once set both flags
  AST_BOTH_FLAGS: assert property (
    src_watchdog && src_trap_conflict && !src_power_on
    |=> reset_cause_status[rsc_pkg::RSC_B_WATCHDOG_TIMEOUT]
        && reset_cause_status[rsc_pkg::RSC_B_TRAP_CONFLICT])
    else $error("simultaneous sources not all recorded");

  // Full write with no events stores exactly the written bits
  AST_WRITE_STORES: assert property (
    wr_cause && wb_sel_i[1:0] == 2'b11 && !any_src && !sleep_entered && !idle_entered
    |=> reset_cause_status == ($past(wr_word) & rsc_pkg::RSC_CAUSE_IMPL))
    else $error("software write not stored");

  // Writing flags without sources never raises the master reset
  AST_WRITE_NO_RESET: assert property (
    wr_cause && !any_src |=> !master_system_reset)
    else $error("software write caused a reset");

  // Unprogrammed fuse forces the watchdog on
  AST_FUSE_WATCHDOG: assert property (
    fused_watchdog_enable |=> watchdog_enable)
    else $error("watchdog disabled despite unprogrammed fuse");

  // Supply dip is a cold reset, reset instruction alone is warm
  AST_COLD_WARM: assert property (
    src_supply_dip |=> cold_reset && !warm_reset)
    else $error("brown-out not treated as cold reset");

  AST_WARM_INSTR: assert property (
    src_reset_instr && !cold_src |=> warm_reset && !cold_reset)
    else $error("reset instruction not treated as warm reset");

  // Warm reset keeps other flags and drops the soft watchdog enable
  AST_WARM_KEEPS_FLAGS: assert property (
    src_reset_instr && !src_power_on && !wr_cause && reset_cause_status[rsc_pkg::RSC_B_TRAP_CONFLICT]
    |=> reset_cause_status[rsc_pkg::RSC_B_TRAP_CONFLICT]
        && !reset_cause_status[rsc_pkg::RSC_B_SOFT_WATCHDOG])
    else $error("warm reset disturbed the kept state");

  // Supply dip and power-on flags record their events
  AST_DIP_FLAG: assert property (
    src_supply_dip |=> reset_cause_status[rsc_pkg::RSC_B_SUPPLY_DIP])
    else $error("supply dip flag not set");

  AST_POWER_FLAG: assert property (
    src_power_on |=> reset_cause_status[rsc_pkg::RSC_B_POWER_ON])
    else $error("power-on flag not set");

  // Pin reset marks its flag even against a software clear
  AST_PIN_FLAG: assert property (
    external_pin_reset |=> reset_cause_status[rsc_pkg::RSC_B_EXTERNAL_PIN])
    else $error("external pin flag not set");

  // Reset instruction marks its flag
  AST_INSTR_FLAG: assert property (
    src_reset_instr |=> reset_cause_status[rsc_pkg::RSC_B_RESET_INSTR])
    else $error("reset instruction flag not set");

  // Configuration mismatch marks its flag
  AST_MISMATCH_FLAG: assert property (
    src_config_mismatch |=> reset_cause_status[rsc_pkg::RSC_B_CONFIG_MISMATCH])
    else $error("configuration mismatch flag not set");

  // Illegal opcode marks the illegal-condition flag and resets
  AST_OPCODE_ILLEGAL: assert property (
    src_illegal_opcode |=> reset_cause_status[rsc_pkg::RSC_B_ILLEGAL_COND] && master_system_reset)
    else $error("illegal opcode not recorded as illegal condition");

  // Power-on is a cold reset
  AST_POWER_ON_COLD: assert property (
    src_power_on |=> cold_reset && !warm_reset)
    else $error("power-on not treated as cold reset");

  // Sleep entry marks its status bit
  AST_SLEEP_FLAG: assert property (
    sleep_entered |=> reset_cause_status[rsc_pkg::RSC_B_SLEEP])
    else $error("sleep bit not set");

  // Idle entry marks its status bit
  AST_IDLE_FLAG: assert property (
    idle_entered |=> reset_cause_status[rsc_pkg::RSC_B_IDLE])
    else $error("idle bit not set");

  // Standby output mirrors its register bit
  AST_STANDBY_COPY: assert property (
    regulator_standby_bit == reset_cause_status[rsc_pkg::RSC_B_REG_STANDBY])
    else $error("standby output differs from its register bit");

endmodule

// *** dv/rsc_src_model.sv ***
// Model of the on-chip reset sources and power-saving events.
// Assumes the bench asks for source levels right after a rising edge.
`timescale 1ns/1ns
module rsc_src_model (
  // Clock
  input wire logic core_clk,
  // Requests from the bench
  input wire logic [11:0] req,
  input wire logic slow,
  // Levels: 0 power-on .. 9 security, 10 sleep, 11 idle
  output logic [11:0] src
);
  logic [11:0] dly;
  // Levels change only after an edge, promptly or one cycle late
  always_ff @(posedge core_clk) begin
    dly <= req;
    src <= slow ? dly : req;
  end
endmodule

// *** dv/rsc_reset_combiner_tb.sv ***
// Self-checking bench of the reset source combiner.
// Assumes the source model drives the reset lines and the bench is the bus master.
`timescale 1ns/1ns
module rsc_reset_combiner_tb;
  logic core_clk, rst_n, fuse, slow, cyc, stb, we, ack, chk;
  logic rst_o, cold, warm, wden, stby;
  logic [11:0] req, s;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q, seed, m_rd;
  logic [15:0] m_cause, nx;
  logic m_rst, m_cold, m_warm, m_wden;
  int fail_count, checked;
  rsc_src_model u_rsc_src_model (.core_clk(core_clk), .req(req), .slow(slow), .src(s));
  rsc_reset_combiner u_rsc_reset_combiner (.core_clk(core_clk), .rst_n(rst_n),
    .src_power_on(s[0]), .src_supply_dip(s[1]), .external_pin_reset(s[2]), .src_reset_instr(s[3]),
    .src_watchdog(s[4]), .src_config_mismatch(s[5]), .src_trap_conflict(s[6]),
    .src_illegal_opcode(s[7]), .src_uninit_wreg(s[8]), .src_security(s[9]),
    .sleep_entered(s[10]), .idle_entered(s[11]), .fused_watchdog_enable(fuse),
    .master_system_reset(rst_o), .cold_reset(cold), .warm_reset(warm), .watchdog_enable(wden),
    .regulator_standby_bit(stby), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat));
  // Clock of 50 ns
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // Reference model of outputs and flags
  always @(posedge core_clk) begin
    if (!rst_n) begin
      m_cause <= rsc_pkg::RSC_CAUSE_RESET;
      {m_rst, m_cold, m_warm, m_wden} <= 4'hd;
      m_rd <= 32'h0;
    end else begin
      nx = m_cause;
      if (cyc && stb && we && ack && adr == 8'h00) begin
        if (sel[0]) nx[7:0] = dat[7:0];
        if (sel[1]) nx[15:8] = dat[15:8];
      end
      if (|s[9:0]) nx[5] = 1'b0;
      // Power-on keeps only this cycle's events; otherwise events are ORed in
      nx = {s[6], |s[9:7], 4'h0, s[5], 1'b0, s[2], s[3], 1'b0, s[4], s[10], s[11], s[1], s[0]}
        | (s[0] ? 16'h0000 : nx);
      nx = nx & rsc_pkg::RSC_CAUSE_IMPL;
      m_cause <= nx;
      m_rst <= |s[9:0];
      m_cold <= s[0] | s[1];
      m_warm <= |s[9:2] & !(s[0] | s[1]);
      m_wden <= fuse | nx[5];
      // Read data is the register value at the edge that takes the request
      if (cyc && stb && !ack)
        m_rd <= adr == 8'h00 ? {16'h0, m_cause} : adr == 8'h04 ? {22'h0, s[9:0]} : 32'h0;
    end
  end
  // Compare the reset and control outputs every cycle
  always @(negedge core_clk) begin
    if (chk) begin
      check(rst_o, m_rst);
      check({cold, warm}, {m_cold, m_warm});
      check(wden, m_wden);
      check(stby, m_cause[8]);
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] bs);
    int n;
    n = 0;
    @(posedge core_clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, bs};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd_cause;
    wb(0, 8'h00, 0, 4'h3);
    check(q, m_rd);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Watchdog on a hung run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    {rst_n, fuse, slow, cyc, stb, we, chk, req, adr, sel, dat} = '0;
    seed = 32'h7538;
    fail_count = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    repeat (2) @(posedge core_clk);
    chk = 1;
    rd_cause();
    wb(1, 8'h00, 0, 4'h3);
    // Each source and event alone, then cleared by software
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk) req <= 12'h1 << i;
      @(posedge core_clk) req <= 0;
      repeat (3) @(posedge core_clk);
      rd_cause();
      wb(1, 8'h00, 0, 4'h3);
    end
    // Software sets every flag, then clears only the low byte
    wb(1, 8'h00, 32'hffff_ffff, 4'h3);
    rd_cause();
    wb(1, 8'h00, 0, 4'h1);
    rd_cause();
    wb(1, 8'h04, 32'hffff, 4'h3);
    wb(1, 8'h08, 32'hffff, 4'h3);
    rd_cause();
    wb(0, 8'h08, 0, 4'h3);
    check(q, 0);
    // Random mixes of sources, fuse and model speed
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      @(posedge core_clk);
      req <= seed[11:0] & (seed[20:17] == 0 ? 12'hfff : 12'hffe);
      {fuse, slow} <= seed[13:12];
      repeat (3) @(posedge core_clk);
      wb(0, 8'h04, 0, 4'h3);
      check(q, m_rd);
      rd_cause();
      if (seed[24]) wb(1, 8'h00, seed[31:16] ^ seed[15:0], seed[27:24]);
    end
    @(posedge core_clk) req <= 0;
    repeat (4) @(posedge core_clk);
    rd_cause();
    results();
  end
endmodule
